// ==== hdl/port_three_pkg.sv ====
// constants for the port three data register block
package port_three_pkg;
    // register byte addresses on the register bus
    localparam logic [7:0] PORT_THREE_PINS_ADDR = 8'h03;
    localparam logic [7:0] PORT_THREE_MODE_ADDR = 8'h10;
    localparam logic [7:0] TIMER_CTRL_ADDR = 8'h14;
    // reset values of the output latch, mode and routing control registers
    localparam logic [3:0] OUT_LATCH_RESET = 4'h0;
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [4:0] TIMER_CTRL_RESET = 5'h00;
    // mode register fields
    localparam int MODE_ANALOG_BIT = 1;
    localparam int MODE_AMP_BIT = 2;
    // routing control register fields
    localparam int CTL_COMB_LO = 0;
    localparam int CTL_COMB_HI = 1;
    localparam int CTL_T16_BIT = 2;
    localparam int CTL_CMP2_BIT = 3;
    localparam int CTL_T8_BIT = 4;
    localparam logic [1:0] COMB_SEL_LOGIC = 2'h1;
    // mode register reserved bits read back as ones
    localparam logic [4:0] MODE_RSVD_READ = 5'h1f;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== hdl/port_three_pins.sv ====
// port three data register with its AXI4-Lite register slave
`timescale 1ns/1ps
module port_three_pins
    import port_three_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [3:0] input_pins_in,
    input wire logic comparator1_in,
    input wire logic comparator2_in,
    input wire logic ir_amp_in,
    input wire logic stop_mode_recovery_in,
    input wire logic timer_combined_in,
    input wire logic timer16_in,
    input wire logic timer8_in,
    output logic [3:0] output_pins_out,
    output logic [2:0] port_three_mode_out
);

////////////////////////////////////////////////////////////////////////////
// input synchronisers: three stages, change taken when stages 2 and 3 agree

    localparam int NSYNC = 8;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    logic [NSYNC-1:0] s3_q;
    logic [NSYNC-1:0] stable_q;

    assign raw_in = {stop_mode_recovery_in, ir_amp_in, comparator2_in,
                     comparator1_in, input_pins_in};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++)
        begin : g_sync
            always_ff @(posedge mclk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    s3_q[gi] <= 1'b0;
                    stable_q[gi] <= 1'b0;
                end
                else
                begin
                    s1_q[gi] <= raw_in[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi])
                    begin
                        stable_q[gi] <= s3_q[gi];
                    end
                end
            end
        end
    endgenerate

    logic [3:0] pin_lvl;
    logic cmp1_lvl;
    logic cmp2_lvl;
    logic amp_lvl;
    logic smr_lvl;
    assign pin_lvl = stable_q[3:0];
    assign cmp1_lvl = stable_q[4];
    assign cmp2_lvl = stable_q[5];
    assign amp_lvl = stable_q[6];
    assign smr_lvl = stable_q[7];

////////////////////////////////////////////////////////////////////////////
// registers

    logic [3:0] out_latch_q;
    logic [2:0] mode_q;
    logic [4:0] ctl_q;
    logic aw_hold_q;
    logic w_hold_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic do_write;
    logic aw_ok;
    logic w_ok;

    assign aw_ok = aw_hold_q | (s_axi_awvalid_in & s_axi_awready_out);
    assign w_ok = w_hold_q | (s_axi_wvalid_in & s_axi_wready_out);
    assign do_write = aw_ok & w_ok & !s_axi_bvalid_out;

    logic [7:0] wa;
    logic [31:0] wd;
    logic wl0;
    assign wa = aw_hold_q ? awaddr_q : s_axi_awaddr_in;
    assign wd = w_hold_q ? wdata_q : s_axi_wdata_in;
    assign wl0 = w_hold_q ? wstrb_q[0] : s_axi_wstrb_in[0];

    // write address and data taken in either order, response after both
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out <= 1'b0;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= RESP_OKAY;
        end
        else
        begin
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out <= 1'b0;
            if (s_axi_awvalid_in & s_axi_awready_out)
            begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in & s_axi_wready_out)
            begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata_in;
                wstrb_q <= s_axi_wstrb_in;
            end
            if (do_write)
            begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                if (wa == PORT_THREE_PINS_ADDR || wa == PORT_THREE_MODE_ADDR
                    || wa == TIMER_CTRL_ADDR)
                    s_axi_bresp_out <= RESP_OKAY;
                else
                    s_axi_bresp_out <= RESP_SLVERR;
            end
            else
            begin
                if (s_axi_bvalid_out & s_axi_bready_in)
                    s_axi_bvalid_out <= 1'b0;
                if (!aw_ok && !s_axi_awready_out && !s_axi_bvalid_out)
                    s_axi_awready_out <= s_axi_awvalid_in;
                if (!w_ok && !s_axi_wready_out && !s_axi_bvalid_out)
                    s_axi_wready_out <= s_axi_wvalid_in;
            end
        end
    end

    // latches cleared by full reset only; no recovery input reaches them
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            out_latch_q <= OUT_LATCH_RESET;
            mode_q <= MODE_RESET;
            ctl_q <= TIMER_CTRL_RESET;
        end
        else if (do_write && wl0)
        begin
            case (wa)
                PORT_THREE_PINS_ADDR: out_latch_q <= wd[7:4];
                PORT_THREE_MODE_ADDR: mode_q <= wd[2:0];
                TIMER_CTRL_ADDR: ctl_q <= wd[4:0];
                default: ;
            endcase
        end
    end

////////////////////////////////////////////////////////////////////////////
// pin drive with alternate functions

    logic analog;
    logic amp_en;
    assign analog = mode_q[MODE_ANALOG_BIT];
    assign amp_en = mode_q[MODE_AMP_BIT];

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            output_pins_out <= OUT_LATCH_RESET;
            port_three_mode_out <= MODE_RESET;
        end
        else
        begin
            port_three_mode_out <= mode_q;
            output_pins_out[3] <= out_latch_q[3];
            output_pins_out[2] <= (ctl_q[CTL_COMB_HI:CTL_COMB_LO]
                == COMB_SEL_LOGIC) ? timer_combined_in : out_latch_q[2];
            output_pins_out[1] <= ctl_q[CTL_T16_BIT] ?
                timer16_in : out_latch_q[1];
            output_pins_out[0] <= ctl_q[CTL_CMP2_BIT] ? cmp2_lvl :
                (ctl_q[CTL_T8_BIT] ? timer8_in : out_latch_q[0]);
        end
    end

////////////////////////////////////////////////////////////////////////////
// read path

    logic [3:0] in_view;
    always_comb
    begin
        // recovery source select has no register here, so only analog
        // mode switches this bit over to the recovery condition
        in_view[3] = analog ? !smr_lvl : pin_lvl[3];
        in_view[2] = analog ? cmp2_lvl : pin_lvl[2];
        if (amp_en)
            in_view[1] = amp_lvl;
        else if (analog)
            in_view[1] = cmp1_lvl;
        else
            in_view[1] = pin_lvl[1];
        in_view[0] = analog ? 1'b1 : pin_lvl[0];
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= RESP_OKAY;
        end
        else if (s_axi_arvalid_in & s_axi_arready_out)
        begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out <= RESP_OKAY;
            case (s_axi_araddr_in)
                PORT_THREE_PINS_ADDR:
                    s_axi_rdata_out <= {24'h0, out_latch_q, in_view};
                PORT_THREE_MODE_ADDR:
                    s_axi_rdata_out <= {24'h0, MODE_RSVD_READ, mode_q};
                TIMER_CTRL_ADDR:
                    s_axi_rdata_out <= {27'h0, ctl_q};
                default:
                begin
                    s_axi_rdata_out <= 32'h0000_0000;
                    s_axi_rresp_out <= RESP_SLVERR;
                end
            endcase
        end
        else
        begin
            if (s_axi_rvalid_out & s_axi_rready_in)
                s_axi_rvalid_out <= 1'b0;
            s_axi_arready_out <= s_axi_arvalid_in & !s_axi_arready_out
                & !(s_axi_rvalid_out & !s_axi_rready_in);
        end
    end

endmodule

// ==== sim/port_three_pins_monitor.sv ====
// bus and pin checks for the port three data register
`timescale 1ns/1ps
module port_three_pins_monitor
    import port_three_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [1:0] s_axi_rresp_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [3:0] output_pins_out,
    input wire logic [2:0] port_three_mode_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    sequence ar_taken;
        s_axi_arvalid_in && s_axi_arready_out;
    endsequence
    bresp_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in
        |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write response moved");
    rdata_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in
        |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data moved");
    read_answer_a: assert property (ar_taken |=> s_axi_rvalid_out)
        else $error("no read answer");
    upper_zero_a: assert property (s_axi_rvalid_out
        |-> s_axi_rdata_out[31:8] == 24'h0) else $error("upper bits");
    err_zero_a: assert property (s_axi_rvalid_out &&
        s_axi_rresp_out == RESP_SLVERR |-> s_axi_rdata_out == 32'h0)
        else $error("error data");
    reset_clear_a: assert property ($rose(rst_n_in) |->
        output_pins_out == 4'h0) else $error("pins after reset");
    pin7_cause_a: assert property ($changed(output_pins_out[3]) |->
        $past(s_axi_bvalid_out) || $past(s_axi_bvalid_out, 2))
        else $error("pin seven moved");
    mode_cause_a: assert property ($changed(port_three_mode_out) |->
        $past(s_axi_bvalid_out) || $past(s_axi_bvalid_out, 2))
        else $error("mode moved");
endmodule
bind port_three_pins port_three_pins_monitor i_port_three_pins_monitor (
    .mclk_in, .rst_n_in, .s_axi_bresp_out, .s_axi_bvalid_out,
    .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out,
    .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
    .s_axi_rready_in, .output_pins_out, .port_three_mode_out);

// ==== sim/core_model.sv ====
// register bus master standing in for the processor core
`timescale 1ns/1ps
module core_model (
    input wire logic clk_in,
    output logic [7:0] aw_out = 8'h00,
    output logic awv_out = 1'b0,
    input wire logic awr_in,
    output logic [31:0] wd_out = 32'h0,
    output logic wv_out = 1'b0,
    input wire logic wr_in,
    input wire logic [1:0] br_in,
    input wire logic bv_in,
    output logic brdy_out = 1'b0,
    output logic [7:0] ar_out = 8'h00,
    output logic arv_out = 1'b0,
    input wire logic arr_in,
    input wire logic [31:0] rd_in,
    input wire logic [1:0] rr_in,
    input wire logic rv_in,
    output logic rrdy_out = 1'b0
);
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      output logic [1:0] r);
        @(posedge clk_in);
        aw_out <= a;
        wd_out <= {24'h0, d};
        awv_out <= 1'b1;
        wv_out <= 1'b1;
        brdy_out <= 1'b1;
        do
        begin
            @(posedge clk_in);
            if (awr_in)
                awv_out <= 1'b0;
            if (wr_in)
                wv_out <= 1'b0;
        end while (!bv_in);
        r = br_in;
        brdy_out <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge clk_in);
        ar_out <= a;
        arv_out <= 1'b1;
        rrdy_out <= 1'b1;
        do
        begin
            @(posedge clk_in);
            if (arr_in)
                arv_out <= 1'b0;
        end while (!rv_in);
        d = rd_in;
        r = rr_in;
        rrdy_out <= 1'b0;
    endtask
endmodule

// ==== sim/port_three_pins_tb.sv ====
// self-checking bench for the port three data register
`timescale 1ns/1ps
module port_three_pins_tb;
    import port_three_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [3:0] pins = 4'ha;
    logic [2:0] tmr = 3'h7;
    logic [3:0] strb = 4'h1;
    logic [2:0] pmode;
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] aw, ar;
    logic [31:0] wd, rdat;
    logic awv, awr, wv, wr, bv, brdy, arv, arr, rv, rrdy;
    logic [1:0] br, rr;
    logic [3:0] opins;
    logic [4:0] rt [5] = '{5'h01, 5'h03, 5'h04, 5'h08, 5'h10};
    logic [3:0] rp [5] = '{4'h4, 4'h0, 4'h2, 4'h1, 4'h1};
    int n_mismatch = 0;
    int n_compared = 0;
    core_model i_core_model (.clk_in(mclk_in), .aw_out(aw), .awv_out(awv),
        .awr_in(awr), .wd_out(wd), .wv_out(wv), .wr_in(wr), .br_in(br),
        .bv_in(bv), .brdy_out(brdy), .ar_out(ar), .arv_out(arv),
        .arr_in(arr), .rd_in(rdat), .rr_in(rr), .rv_in(rv),
        .rrdy_out(rrdy));
    port_three_pins i_port_three_pins (.mclk_in, .rst_n_in,
        .s_axi_awaddr_in(aw), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
        .s_axi_wstrb_in(strb), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr),
        .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(brdy),
        .s_axi_araddr_in(ar), .s_axi_arvalid_in(arv),
        .s_axi_arready_out(arr), .s_axi_rdata_out(rdat),
        .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rrdy),
        .input_pins_in(pins), .comparator1_in(1'b1), .comparator2_in(1'b1),
        .ir_amp_in(1'b0), .stop_mode_recovery_in(pins[3]),
        .timer_combined_in(tmr[2]), .timer16_in(tmr[1]),
        .timer8_in(tmr[0]), .output_pins_out(opins),
        .port_three_mode_out(pmode));
    // recovery input follows pin three, so analog bit 3 reads its inverse
    function automatic logic [3:0] lo(input logic [1:0] m);
        lo = m[0] ? {!pins[3], 3'h7} : pins;
        if (m[1])
            lo[1] = 1'b0;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
        forever #50 mclk_in = ~mclk_in;
    initial
    begin
        #200000;
        n_mismatch++;
        close_out();
    end
    initial
    begin
        repeat (4) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        repeat (5) @(posedge mclk_in);
        i_core_model.rd(PORT_THREE_PINS_ADDR, d, r);
        chk(d, {24'h0, 4'h0, pins});
        i_core_model.wr(PORT_THREE_PINS_ADDR, 8'h9f, r);
        chk(32'(r), 32'(RESP_OKAY));
        repeat (3) @(posedge mclk_in);
        chk(32'(opins), 32'h9);
        $display("test latch done");
        for (int p = 0; p < 2; p++)
        begin
            pins <= p[0] ? 4'h5 : 4'ha;
            for (int m = 0; m < 4; m++)
            begin
                i_core_model.wr(PORT_THREE_MODE_ADDR, {5'h0, m[1:0], 1'b0}, r);
                repeat (5) @(posedge mclk_in);
                chk({29'h0, pmode}, {29'h0, m[1:0], 1'b0});
                i_core_model.rd(PORT_THREE_MODE_ADDR, d, r);
                chk(d, {24'h0, MODE_RSVD_READ, m[1:0], 1'b0});
                i_core_model.rd(PORT_THREE_PINS_ADDR, d, r);
                chk(d, {24'h0, 4'h9, lo(m[1:0])});
            end
        end
        $display("test input views done");
        i_core_model.wr(PORT_THREE_PINS_ADDR, 8'hf0, r);
        for (int i = 0; i < 5; i++)
        begin
            i_core_model.wr(TIMER_CTRL_ADDR, {3'h0, rt[i]}, r);
            i_core_model.wr(PORT_THREE_PINS_ADDR, 8'h00, r);
            repeat (3) @(posedge mclk_in);
            chk(32'(opins), 32'(rp[i]));
            i_core_model.rd(PORT_THREE_PINS_ADDR, d, r);
            chk(32'(d[7:4]), 32'h0);
        end
        strb <= 4'h0;
        i_core_model.wr(PORT_THREE_PINS_ADDR, 8'hf0, r);
        strb <= 4'h1;
        i_core_model.rd(PORT_THREE_PINS_ADDR, d, r);
        chk(32'(d[7:4]), 32'h0);
        $display("test routing done");
        i_core_model.rd(8'h20, d, r);
        chk(32'(r), 32'(RESP_SLVERR));
        chk(d, 32'h0);
        i_core_model.wr(8'h20, 8'hff, r);
        chk(32'(r), 32'(RESP_SLVERR));
        $display("test unmapped done");
        close_out();
    end
endmodule
